// ### src/input_router_pkg.sv
package input_router_pkg;

  // Number of physical input contacts on the connector.
  localparam int NUM_CONTACTS = 10;
  // Number of 16-bit selector words.
  localparam int NUM_WORDS = 5;
  // Selector digits packed into each word, digit 1 in the low nibble.
  localparam int DIGITS_PER_WORD = 4;
  // Width of one selector digit.
  localparam int DIGIT_W = 4;
  // Width of one selector word.
  localparam int WORD_W = 16;
  // Width of the register address port.
  localparam int ADDR_W = 4;
  // Total number of routed function slots.
  localparam int NUM_SLOTS = NUM_WORDS * DIGITS_PER_WORD;

  // Register addresses: selector words sit at 0 to 4.
  localparam logic [3:0] ADDR_MAP_BASE = 4'h0;
  // Read-only live contact state.
  localparam logic [3:0] ADDR_STATUS = 4'h5;

  // Values after reset of the five selector words, word 0 lowest.
  localparam logic [4:0][15:0] MAP_RESET = {
    16'h0000, 16'h0000, 16'h00a9, 16'h8765, 16'h4321};

  // Selector codes with a special meaning.
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_LAST_CONTACT = 4'ha;
  localparam logic [3:0] SEL_ALWAYS = 4'hf;

  // Slot of absolute_position_wipe (word 4, digit 4).
  localparam int WIPE_SLOT = 19;

  // Least hold time of the position wipe request, in milliseconds.
  localparam longint unsigned WIPE_HOLD_MS = 64'd500;
  // System clock rate in hertz.
  localparam longint unsigned CLOCK_HZ = 64'd40000000;
  // Least hold time in clock cycles, rounded up.
  localparam longint unsigned WIPE_HOLD_CYCLES =
    (WIPE_HOLD_MS * CLOCK_HZ + 64'd999) / 64'd1000;

  // Decodes one selector digit against the contact vector.
  function automatic logic route_digit(
    input logic [3:0] digit,
    input logic [9:0] contacts
  );
    logic hit;
    hit = 1'b0;
    if (digit == SEL_ALWAYS) begin
      hit = 1'b1;
    end else if (digit != SEL_NONE && digit <= SEL_LAST_CONTACT) begin
      hit = contacts[digit - 4'h1];
    end
    return hit;
  endfunction

endpackage

// ### src/selector_mux.sv
`timescale 1ns/1ps
// One function slot: picks its source from the contacts by its digit.
module selector_mux (
  // Selector and contacts.
  input  wire logic [3:0] i_digit,
  input  wire logic [9:0] i_contacts,
  // Routed function level.
  output logic            o_active
);

  // Codes B to E name no contact; they leave the slot inactive,
  // which is the safe reading for a drive input.
  always_comb begin
    o_active = input_router_pkg::route_digit(i_digit, i_contacts);
  end

endmodule // selector_mux

// ### src/wipe_hold_qualifier.sv
`timescale 1ns/1ps
// Qualifies a level that must stand unbroken for a least time.
module wipe_hold_qualifier #(
  parameter int unsigned HOLD_CYCLES = 20000000
) (
  // Clock and reset.
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  // Raw request level.
  input  wire logic i_level,
  // One-cycle pulse once the hold time is met.
  output logic      o_confirmed
);

  localparam int CW = $clog2(HOLD_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);

  // Cycles the level has stood high so far.
  logic [CW-1:0] held_reg;

  // Any drop restarts the count, so short pulses never qualify.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      held_reg <= '0;
    end else if (!i_level) begin
      held_reg <= '0;
    end else if (held_reg != CW'(HOLD_CYCLES)) begin
      held_reg <= held_reg + CW'(1);
    end
  end

  // The pulse fires once per hold; the count saturates afterwards.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_confirmed <= 1'b0;
    end else begin
      o_confirmed <= i_level && (held_reg == LAST);
    end
  end

endmodule // wipe_hold_qualifier

// ### src/input_function_router.sv
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module input_function_router #(
  parameter int unsigned WIPE_HOLD_CYCLES =
    int'(input_router_pkg::WIPE_HOLD_CYCLES)
) (
  // Clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // Register port.
  input  wire logic [3:0]  i_addr,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  output logic      [15:0] o_rd_data,
  // Physical input contacts, bit 0 is the first contact.
  input  wire logic [9:0]  i_contact,
  // Routed function levels, one per selector slot.
  output logic      [19:0] o_func_active,
  // Status view segments, one per contact.
  output logic      [9:0]  o_contact_status,
  // Qualified absolute position wipe, one-cycle pulse.
  output logic             o_wipe_confirmed
);

  ////////////////////////////////////////////////////////////////////////
  // Selector words.

  // The five selector words as software sees them.
  logic [15:0] map_reg [input_router_pkg::NUM_WORDS];
  // Per-slot digit views of those words.
  logic [3:0]  sel [input_router_pkg::NUM_SLOTS];
  // Combinational routing result for every slot.
  logic [19:0] func_next;
  // Registered image of the contacts for the status view.
  logic [9:0]  status_reg;
  // Read data held for the cycle after the read strobe.
  logic [15:0] rd_data_reg;
  // Helper: any register write since reset, at any address, for checking only.
  logic        any_write_reg;

  // Writes are not gated by any save setting: keeping a remap out of
  // non-volatile storage is left to whoever configures the drive.
  // Each word has its own process and resets to its default.
  for (genvar w = 0; w < input_router_pkg::NUM_WORDS; w++) begin : g_word
    always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
        map_reg[w] <= input_router_pkg::MAP_RESET[w];
      end else if (i_wr_en &&
                   i_addr == input_router_pkg::ADDR_MAP_BASE + 4'(w)) begin
        // No shadow copy: the next cycle already routes by it.
        map_reg[w] <= i_wr_data;
      end
    end

    // Digit 1 is the low nibble of the word.
    for (genvar d = 0; d < input_router_pkg::DIGITS_PER_WORD; d++)
    begin : g_digit
      assign sel[w*4+d] = map_reg[w][d*4 +: 4];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Routing.

  // One mux per slot; the slots never look at each other, so any
  // number of them may name the same contact.
  for (genvar s = 0; s < input_router_pkg::NUM_SLOTS; s++) begin : g_slot
    selector_mux u_mux (
      .i_digit    (sel[s]),
      .i_contacts (i_contact),
      .o_active   (func_next[s])
    );
  end

  // Registering the outputs costs one cycle of latency but keeps
  // glitches of the selector decode off the drive's function inputs.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_func_active <= '0;
    end else begin
      o_func_active <= func_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status view.

  // Segment n follows contact n, one clock cycle late.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status_reg <= '0;
    end else begin
      status_reg <= i_contact;
    end
  end

  assign o_contact_status = status_reg;

  ////////////////////////////////////////////////////////////////////////
  // Register reads.

  // Reads answer in the next cycle; unmapped addresses read zero.
  // The answer stands for that one cycle only and then drops to zero,
  // which keeps a missed read from being taken as a later one.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_data_reg <= '0;
    end else if (i_rd_en) begin
      if (i_addr < 4'(input_router_pkg::NUM_WORDS)) begin
        rd_data_reg <= map_reg[i_addr[2:0]];
      end else if (i_addr == input_router_pkg::ADDR_STATUS) begin
        rd_data_reg <= {6'h00, status_reg};
      end else begin
        rd_data_reg <= '0;
      end
    end else begin
      rd_data_reg <= '0;
    end
  end

  assign o_rd_data = rd_data_reg;

  ////////////////////////////////////////////////////////////////////////
  // Position wipe qualification.

  // The far side must hold the request; shorter pulses are dropped.
  wipe_hold_qualifier #(
    .HOLD_CYCLES (WIPE_HOLD_CYCLES)
  ) u_wipe (
    .i_clock     (i_clock),
    .i_rst_b     (i_rst_b),
    .i_level     (o_func_active[input_router_pkg::WIPE_SLOT]),
    .o_confirmed (o_wipe_confirmed)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checking helpers and assertions.

  // Tracks whether software has written any register yet, at any address.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      any_write_reg <= 1'b0;
    end else if (i_wr_en) begin
      any_write_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);

  // A read of the status address.
  sequence s_status_read;
    i_rd_en && i_addr == input_router_pkg::ADDR_STATUS;
  endsequence

  a_status_segments:
    assert property (##1 o_contact_status == $past(i_contact))
    else $error("status segment does not follow its contact");

  a_status_readback:
    assert property (s_status_read |=> o_rd_data[9:0] == $past(i_contact, 2))
    else $error("status read does not show the contacts");

  a_unmapped_zero:
    assert property ((i_rd_en && i_addr > 4'h5) |=> o_rd_data == 16'h0000)
    else $error("unmapped read is not zero");

  // Outside its one cycle the read data must fall back to zero, so a
  // stale word can never be mistaken for a fresh answer.
  a_read_idle_zero:
    assert property (!i_rd_en |=> o_rd_data == 16'h0000)
    else $error("read data stands outside its cycle");

  // The status word has only ten live bits; the rest read as zero.
  a_status_high_zero:
    assert property (s_status_read |=> o_rd_data[15:10] == 6'h00)
    else $error("status read shows bits above the tenth contact");

  for (genvar w = 0; w < input_router_pkg::NUM_WORDS; w++) begin : g_wchk
    // A write of word w.
    sequence s_word_write;
      i_wr_en && i_addr == 4'(w);
    endsequence

    // A read of word w.
    sequence s_word_read;
      i_rd_en && i_addr == 4'(w);
    endsequence

    a_reset_defaults:
      assert property (!any_write_reg |->
                       map_reg[w] == input_router_pkg::MAP_RESET[w])
      else $error("selector word differs from its reset default");

    a_write_effect:
      assert property (s_word_write ##1 sel[w*4] == 4'hf
                       |=> o_func_active[w*4])
      else $error("written selector did not take effect at once");

    a_write_lands:
      assert property (s_word_write |=> map_reg[w] == $past(i_wr_data))
      else $error("selector write did not land");

    // Clearing a digit must drop its function just as fast.
    a_write_clear:
      assert property (s_word_write ##1 sel[w*4] == 4'h0
                       |=> !o_func_active[w*4])
      else $error("cleared selector did not take effect at once");

    // A read hands back the word as it stood at the read edge.
    a_word_readback:
      assert property (s_word_read |=> o_rd_data == $past(map_reg[w]))
      else $error("selector read does not match the word");

    // Writes to the status place or above must leave every word alone.
    a_refused_write:
      assert property ((i_wr_en && i_addr > 4'h4) |=>
                       map_reg[w] == $past(map_reg[w]))
      else $error("refused write changed a selector word");
  end

  for (genvar s = 0; s < input_router_pkg::NUM_SLOTS; s++) begin : g_schk
    a_zero_idle:
      assert property (sel[s] == 4'h0 |=> !o_func_active[s])
      else $error("unrouted function is active");

    a_always_on:
      assert property (sel[s] == 4'hf |=> o_func_active[s])
      else $error("always-on function is not asserted");

    a_contact_path:
      assert property ((sel[s] != 4'h0 && sel[s] <= 4'ha) |=>
                       o_func_active[s] ==
                       $past(i_contact[sel[s] - 4'h1]))
      else $error("function does not follow its contact");

    if (s > 0) begin : g_share
      a_shared_contact:
        assert property (sel[s] == sel[0] |=>
                         o_func_active[s] == o_func_active[0])
        else $error("functions on one contact disagree");
    end
  end

  a_wipe_cause:
    assert property (o_wipe_confirmed |->
                     $past(o_func_active[input_router_pkg::WIPE_SLOT]))
    else $error("wipe confirmed without a held request");

  ////////////////////////////////////////////////////////////////////////
  // Wipe hold checking.

  // Width of the helper run count.
  localparam int RUN_W = $clog2(WIPE_HOLD_CYCLES + 1);
  // Value at which the helper run count stops.
  localparam logic [RUN_W-1:0] RUN_FULL = RUN_W'(WIPE_HOLD_CYCLES);
  // Last count before the hold is met.
  localparam logic [RUN_W-1:0] RUN_LAST = RUN_W'(WIPE_HOLD_CYCLES - 1);

  // Helper: unbroken run of the routed wipe level, for checking only.
  logic [RUN_W-1:0] wipe_run_reg;

  // Counted apart from the qualifier, so that a slip in one of them
  // cannot hide behind the other. The cost is a second counter that
  // synthesis drops, as nothing but the assertions reads it.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wipe_run_reg <= '0;
    end else if (!o_func_active[input_router_pkg::WIPE_SLOT]) begin
      // Any drop starts the run again.
      wipe_run_reg <= '0;
    end else if (wipe_run_reg != RUN_FULL) begin
      // Saturate once the hold is met.
      wipe_run_reg <= wipe_run_reg + RUN_W'(1);
    end
  end

  // The pulse may only come once the level has stood the full hold.
  a_wipe_held:
    assert property (o_wipe_confirmed |-> wipe_run_reg == RUN_FULL)
    else $error("wipe confirmed before the hold time");

  // A level that reaches the hold must be confirmed on the next edge.
  a_wipe_taken:
    assert property ((o_func_active[input_router_pkg::WIPE_SLOT] &&
                      wipe_run_reg == RUN_LAST) |=> o_wipe_confirmed)
    else $error("held wipe request was not confirmed");

  // One hold gives one pulse; the level must drop before another.
  a_wipe_single:
    assert property (o_wipe_confirmed |=> !o_wipe_confirmed)
    else $error("wipe confirmed twice for one hold");

endmodule // input_function_router

// ### dv/contact_driver_model.sv
`timescale 1ns/1ps
// Far-side controller that drives the ten input contacts.
module contact_driver_model (
  // Clock.
  input  wire logic       i_clock,
  // Requested contact pattern and wipe hold request.
  input  wire logic [9:0] i_pattern,
  input  wire logic       i_wipe_go,
  input  wire logic [7:0] i_wipe_len,
  // Contact levels towards the router.
  output logic      [9:0] o_contact
);
  // Cycles left for which the tenth contact is held high.
  logic [7:0] hold_reg = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // The wipe level is held unbroken for the asked length. A short length
  // lets the bench send a pulse that must not count as a request.
  always_ff @(posedge i_clock) begin
    if (i_wipe_go) begin
      hold_reg <= i_wipe_len;
    end else if (hold_reg != 8'h00) begin
      hold_reg <= hold_reg - 8'h01;
    end
  end

  // Contacts change only just after an edge, as a real output would.
  always_ff @(posedge i_clock) begin
    o_contact <= i_pattern | {hold_reg != 8'h00, 9'h000};
  end
endmodule // contact_driver_model

// ### dv/test_input_function_router.sv
`timescale 1ns/1ps
// Self-checking bench for the input function router.
module test_input_function_router;
  localparam int HOLD = 6; // Short wipe hold keeps the run brief.
  logic        clock, rst_b, wr_en, rd_en, wipe_go;
  logic [3:0]  addr;
  logic [15:0] wr_data, rd_data, got;
  logic [9:0]  pattern, contact, status;
  logic [7:0]  wipe_len;
  logic [19:0] func;
  logic        wipe_ok;
  logic [15:0] sh [5]; // Shadow of the selector words.
  int          miscompares, n_checks, wipes;

  input_function_router #(.WIPE_HOLD_CYCLES(HOLD)) dut (
    .i_clock(clock), .i_rst_b(rst_b), .i_addr(addr), .i_wr_data(wr_data),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data),
    .i_contact(contact), .o_func_active(func),
    .o_contact_status(status), .o_wipe_confirmed(wipe_ok));
  contact_driver_model partner (
    .i_clock(clock), .i_pattern(pattern), .i_wipe_go(wipe_go),
    .i_wipe_len(wipe_len), .o_contact(contact));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz.
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Counts confirmed wipe pulses.
  always @(posedge clock) begin
    if (wipe_ok === 1'b1) wipes++;
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [19:0] exp, input logic [19:0] act);
    n_checks++;
    if (act !== exp) begin
      miscompares++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask

  // One-cycle write; the shadow follows only mapped words.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    if (a < 4'h5) sh[a] = d;
  endtask

  // One-cycle read; data stand only in the following cycle.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  // Contacts pass the partner and the router's register in two edges; three are waited.
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // Sends one wipe hold of n cycles and waits for it to die out.
  task automatic pulse(input int n);
    @(posedge clock);
    wipe_go  <= 1'b1;
    wipe_len <= n[7:0];
    @(posedge clock);
    wipe_go <= 1'b0;
    repeat (n + 10) @(posedge clock);
    #1;
  endtask

  // Expected routing worked out from the shadow words.
  function automatic logic [19:0] exp_route(input logic [9:0] c);
    logic [19:0] r;
    logic [3:0]  d;
    r = 20'h0_0000;
    for (int s = 0; s < 20; s++) begin
      d = sh[s / 4][(s % 4) * 4 +: 4];
      if (d == 4'hf) r[s] = 1'b1;
      else if (d != 4'h0 && d <= 4'ha) r[s] = c[d - 4'h1];
    end
    return r;
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog: the tests take well under this span.
  initial begin
    #(20000 * 25);
    miscompares++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, wr_en, rd_en, wipe_go} = 4'h0;
    {addr, wr_data, pattern, wipe_len} = '0;
    for (int i = 0; i < 5; i++) sh[i] = input_router_pkg::MAP_RESET[i];
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(i[3:0], got);
      check({4'h0, sh[i]}, {4'h0, got});
    end
    // Each contact alone must reach only its default function.
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      pattern <= 10'h001 << i;
      settle();
      check(exp_route(pattern), func);
      check({10'h000, pattern}, {10'h000, status});
    end
    $display("test default routing done");
    // Every digit code, shared contacts and the always source.
    // Saving to non-volatile store is taken as off while remapping.
    for (int k = 0; k < 16; k++) begin
      wr(4'h3, {4{k[3:0]}});
      wr(4'h4, {k[3:0], 4'h1, 4'hf, 4'h0});
      rd(4'h3, got);
      check({4'h0, sh[3]}, {4'h0, got});
      @(posedge clock);
      pattern <= k[0] ? 10'h2aa : 10'h155;
      settle();
      check(exp_route(pattern), func);
    end
    $display("test digit codes done");
    // Status word is read-only; unmapped places read zero.
    wr(4'h5, 16'hffff);
    wr(4'h6, 16'hffff);
    rd(4'h5, got);
    check({4'h0, 6'h00, pattern}, {4'h0, got});
    rd(4'h6, got);
    check(20'h0_0000, {4'h0, got});
    $display("test status and refusal done");
    // Wipe from the tenth contact: short hold ignored, full hold taken.
    wr(4'h4, 16'ha000);
    @(posedge clock);
    pattern <= 10'h000;
    settle();
    wipes = 0;
    pulse(HOLD - 2);
    check(20'h0_0000, 20'(wipes));
    pulse(HOLD + 4);
    check(20'h0_0001, 20'(wipes));
    $display("test wipe hold done");
    // A second reset must bring every word back to its default.
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      sh[i] = input_router_pkg::MAP_RESET[i];
      rd(i[3:0], got);
      check({4'h0, sh[i]}, {4'h0, got});
    end
    $display("test second reset done");
    final_report();
  end
endmodule // test_input_function_router
